/* File: hdl/csc_fault_queue.sv */
`timescale 1ns/10ps
module csc_fault_queue
  import csc_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic push_i,
  input wire logic [3:0] code_i,
  input wire logic pop_i,
  output logic [3:0] head_o,
  output logic empty_o
);

  logic [3:0] mem [FQ_DEPTH];
  logic [2:0] wr_ptr;
  logic [2:0] rd_ptr;
  logic [3:0] count;
  logic do_push;
  logic do_pop;

  assign empty_o = (count == 4'h0);
  assign do_pop = pop_i && !empty_o;
  // When full, a new fault is dropped unless a read frees a slot this cycle
  assign do_push = push_i && ((count != 4'(FQ_DEPTH)) || do_pop);
  assign head_o = mem[rd_ptr];

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      for (int i = 0; i < FQ_DEPTH; i++) begin
        mem[i] <= FAULT_NORMAL;
      end
    end else if (do_push) begin
      mem[wr_ptr] <= code_i;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wr_ptr <= 3'h0;
      rd_ptr <= 3'h0;
      count <= 4'h0;
    end else begin
      if (do_push) begin
        wr_ptr <= wr_ptr + 3'h1;
      end
      if (do_pop) begin
        rd_ptr <= rd_ptr + 3'h1;
      end
      count <= count + 4'(do_push) - 4'(do_pop);
    end
  end

endmodule : csc_fault_queue

/* File: hdl/csc_pkg.sv */
package csc_pkg;

  // Serial port
  localparam logic [6:0] DEV_ADDR = 7'h6A;
  localparam logic [7:0] REG_STATUS = 8'h00;
  localparam logic [7:0] REG_CONTROL = 8'h01;
  localparam logic [7:0] READ_UNMAPPED = 8'hFF;
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;

  // Status register fields
  localparam int ST_WDOG_FLAG_BIT = 7;
  localparam int ST_WDOG_EN_BIT = 6;
  localparam logic WDOG_EN_RESET = 1'h0;
  localparam logic WDOG_FLAG_RESET = 1'h0;

  // Control register fields
  localparam int CTL_SOFT_RESET_BIT = 7;

  // Charge phase codes
  localparam logic [1:0] PHASE_READY = 2'h0;
  localparam logic [1:0] PHASE_CHARGING = 2'h1;
  localparam logic [1:0] PHASE_DONE = 2'h2;
  localparam logic [1:0] PHASE_FAULT = 2'h3;

  // Fault codes; codes 1 to 9 come from the core's fault vector
  localparam logic [3:0] FAULT_NORMAL = 4'h0;
  localparam logic [3:0] FAULT_IN_LDO_LOW = 4'hA;
  localparam int FAULT_SOURCES = 10;
  localparam int FQ_DEPTH = 8;

  // Input current cap selection
  localparam logic [2:0] CAP_EXT_RESISTOR = 3'h6;
  localparam logic [2:0] CAP_UNLIMITED_CLAMP = 3'h7;

  // Watchdog period in cycles of the 50 ns clock; value is a plain default
  localparam int unsigned WDOG_CYCLES_DEFAULT = 32'd1000000;

  typedef struct packed {
    logic [2:0] input_current_cap_sel;
    logic ind_en;
    logic term_en;
    logic inhibit;
    logic converter_standby_sel;
  } csc_ctrl_t;

  localparam csc_ctrl_t CTRL_DEFAULT = '{
    input_current_cap_sel: 3'h0,
    ind_en: 1'h1,
    term_en: 1'h1,
    inhibit: 1'h0,
    converter_standby_sel: 1'h0
  };

  typedef enum logic [3:0] {
    ST_IDLE,
    ST_ADDR,
    ST_ACK_ADDR,
    ST_PTR,
    ST_ACK_PTR,
    ST_WDATA,
    ST_ACK_WDATA,
    ST_RDATA,
    ST_RACK
  } csc_i2c_state_t;

endpackage : csc_pkg

/* File: hdl/csc_regs.sv */
`timescale 1ns/10ps
module csc_regs
  import csc_pkg::*;
#(
  parameter int unsigned WDOG_CYCLES = WDOG_CYCLES_DEFAULT
) (
  input wire logic CLOCK_I,
  input wire logic RESET_I,
  input wire logic SCL_I,
  input wire logic SDA_I,
  output logic SDA_O,
  output logic SDA_OEN_O,
  input wire logic [1:0] PHASE_I,
  input wire logic [8:0] FAULT_COND_I,
  input wire logic LDO_LOW_I,
  input wire logic INPUT_UVLO_I,
  output logic STAT_PIN_O,
  output logic STAT_PIN_OEN_O,
  output logic [2:0] INPUT_CAP_SEL_O,
  output logic HOST_MODE_O,
  output logic TERM_EN_O,
  output logic CHARGE_INHIBIT_O,
  output logic CONVERTER_STANDBY_O,
  output logic WDOG_EXPIRED_O
);

  // Lowest-numbered active source wins; index i stands for code i+1
  function automatic logic [3:0] lowest_code(input logic [FAULT_SOURCES-1:0] v);
    logic [3:0] code;
    code = FAULT_NORMAL;
    for (int i = FAULT_SOURCES - 1; i >= 0; i--) begin
      if (v[i]) begin
        code = 4'(i + 1);
      end
    end
    return code;
  endfunction : lowest_code

  logic scl_s1;
  logic scl_s2;
  logic scl_s3;
  logic sda_s1;
  logic sda_s2;
  logic sda_s3;
  logic scl_rise;
  logic scl_fall;
  logic start_det;
  logic stop_det;
  csc_i2c_state_t state;
  logic [3:0] bit_cnt;
  logic [7:0] rx_shift;
  logic [7:0] tx_byte;
  logic [7:0] ptr;
  logic rw;
  logic sda_low;
  logic read_load;
  logic wr_stb;
  logic [7:0] read_value;
  csc_ctrl_t ctrl;
  logic watchdog_timer_on;
  logic watchdog_expired_flag;
  logic host_mode;
  logic [31:0] wdog_cnt;
  logic wdog_expire;
  logic uvlo_d;
  logic leave_arm;
  logic [FAULT_SOURCES-1:0] cond;
  logic [FAULT_SOURCES-1:0] cond_d;
  logic [FAULT_SOURCES-1:0] pend;
  logic [FAULT_SOURCES-1:0] grant_vec;
  logic [3:0] push_code;
  logic q_pop;
  logic [3:0] q_head;
  logic q_empty;
  logic [3:0] fault_field;
  logic [1:0] phase_eff;

  // Pin synchronisers; edges are found between the second and third stage
  always_ff @(posedge CLOCK_I) begin
    if (RESET_I) begin
      scl_s1 <= 1'h1;
      scl_s2 <= 1'h1;
      scl_s3 <= 1'h1;
      sda_s1 <= 1'h1;
      sda_s2 <= 1'h1;
      sda_s3 <= 1'h1;
    end else begin
      scl_s1 <= SCL_I;
      scl_s2 <= scl_s1;
      scl_s3 <= scl_s2;
      sda_s1 <= SDA_I;
      sda_s2 <= sda_s1;
      sda_s3 <= sda_s2;
    end
  end

  assign scl_rise = scl_s2 && !scl_s3;
  assign scl_fall = !scl_s2 && scl_s3;
  assign start_det = scl_s2 && scl_s3 && sda_s3 && !sda_s2;
  assign stop_det = scl_s2 && scl_s3 && !sda_s3 && sda_s2;

  always_comb begin
    case (ptr)
      REG_STATUS: read_value = {watchdog_expired_flag, watchdog_timer_on, phase_eff, fault_field};
      REG_CONTROL: read_value = {1'h0, ctrl};
      default: read_value = READ_UNMAPPED;
    endcase
  end

  assign read_load = scl_fall && !start_det && !stop_det &&
                     ((state == ST_ACK_ADDR && rw) || state == ST_RACK);
  assign wr_stb = scl_fall && !start_det && !stop_det &&
                  state == ST_WDATA && bit_cnt == BITS_PER_BYTE;

  always_ff @(posedge CLOCK_I) begin
    if (RESET_I) begin
      state <= ST_IDLE;
      bit_cnt <= 4'h0;
      rx_shift <= 8'h00;
      tx_byte <= 8'hFF;
      ptr <= 8'h00;
      rw <= 1'h0;
      sda_low <= 1'h0;
    end else if (stop_det) begin
      state <= ST_IDLE;
      sda_low <= 1'h0;
    end else if (start_det) begin
      state <= ST_ADDR;
      bit_cnt <= 4'h0;
      sda_low <= 1'h0;
    end else if (scl_rise) begin
      case (state)
        ST_ADDR, ST_PTR, ST_WDATA: begin
          rx_shift <= {rx_shift[6:0], sda_s2};
          bit_cnt <= bit_cnt + 4'h1;
        end
        ST_RDATA: begin
          bit_cnt <= bit_cnt + 4'h1;
        end
        ST_RACK: begin
          // A not-acknowledge ends the read
          if (sda_s2) begin
            state <= ST_IDLE;
          end
        end
        default: begin
        end
      endcase
    end else if (scl_fall) begin
      case (state)
        ST_ADDR: begin
          if (bit_cnt == BITS_PER_BYTE) begin
            if (rx_shift[7:1] == DEV_ADDR) begin
              rw <= rx_shift[0];
              sda_low <= 1'h1;
              state <= ST_ACK_ADDR;
            end else begin
              state <= ST_IDLE;
            end
          end
        end
        ST_ACK_ADDR: begin
          bit_cnt <= 4'h0;
          if (rw) begin
            tx_byte <= read_value;
            sda_low <= !read_value[7];
            state <= ST_RDATA;
          end else begin
            sda_low <= 1'h0;
            state <= ST_PTR;
          end
        end
        ST_PTR: begin
          if (bit_cnt == BITS_PER_BYTE) begin
            ptr <= rx_shift;
            sda_low <= 1'h1;
            state <= ST_ACK_PTR;
          end
        end
        ST_ACK_PTR, ST_ACK_WDATA: begin
          sda_low <= 1'h0;
          bit_cnt <= 4'h0;
          state <= ST_WDATA;
        end
        ST_WDATA: begin
          if (bit_cnt == BITS_PER_BYTE) begin
            sda_low <= 1'h1;
            state <= ST_ACK_WDATA;
          end
        end
        ST_RDATA: begin
          if (bit_cnt == BITS_PER_BYTE) begin
            sda_low <= 1'h0;
            state <= ST_RACK;
          end else begin
            sda_low <= !tx_byte[3'(4'h7 - bit_cnt)];
          end
        end
        ST_RACK: begin
          // Pointer does not advance, so repeated reads walk the fault queue
          bit_cnt <= 4'h0;
          tx_byte <= read_value;
          sda_low <= !read_value[7];
          state <= ST_RDATA;
        end
        default: begin
        end
      endcase
    end
  end

  // Open drain: only ever pull low, enable active low
  always_ff @(posedge CLOCK_I) begin
    if (RESET_I) begin
      SDA_O <= 1'h0;
      SDA_OEN_O <= 1'h1;
    end else begin
      SDA_O <= 1'h0;
      SDA_OEN_O <= !sda_low;
    end
  end

  // Control register and watchdog enable
  always_ff @(posedge CLOCK_I) begin
    if (RESET_I) begin
      ctrl <= CTRL_DEFAULT;
      watchdog_timer_on <= WDOG_EN_RESET;
    end else if (wr_stb && ptr == REG_CONTROL) begin
      if (rx_shift[CTL_SOFT_RESET_BIT]) begin
        ctrl <= CTRL_DEFAULT;
        watchdog_timer_on <= WDOG_EN_RESET;
      end else begin
        ctrl <= csc_ctrl_t'(rx_shift[6:0]);
      end
    end else if (wr_stb && ptr == REG_STATUS) begin
      // only the enable bit is writable
      watchdog_timer_on <= rx_shift[ST_WDOG_EN_BIT];
    end else if (wdog_expire) begin
      ctrl <= CTRL_DEFAULT;
    end
  end

  always_ff @(posedge CLOCK_I) begin
    if (RESET_I) begin
      wdog_cnt <= 32'h0;
    end else if (!watchdog_timer_on || wdog_expire) begin
      wdog_cnt <= 32'h0;
    end else if (wr_stb && ptr == REG_STATUS && rx_shift[ST_WDOG_EN_BIT]) begin
      wdog_cnt <= 32'h0;
    end else begin
      wdog_cnt <= wdog_cnt + 32'h1;
    end
  end

  assign wdog_expire = watchdog_timer_on && (wdog_cnt == 32'(WDOG_CYCLES - 1));

  // sticky expiry flag; a new expiry beats the clear by a read
  always_ff @(posedge CLOCK_I) begin
    if (RESET_I) begin
      watchdog_expired_flag <= WDOG_FLAG_RESET;
    end else if (wdog_expire) begin
      watchdog_expired_flag <= 1'h1;
    end else if (read_load && ptr == REG_STATUS) begin
      watchdog_expired_flag <= 1'h0;
    end
  end

  // host mode entered by a serial write, left on expiry
  always_ff @(posedge CLOCK_I) begin
    if (RESET_I) begin
      host_mode <= 1'h0;
    end else if (wdog_expire) begin
      host_mode <= 1'h0;
    end else if (wr_stb) begin
      host_mode <= 1'h1;
    end
  end

  // remember leaving lockout while the regulator is still low
  always_ff @(posedge CLOCK_I) begin
    if (RESET_I) begin
      uvlo_d <= 1'h0;
      leave_arm <= 1'h0;
    end else begin
      uvlo_d <= INPUT_UVLO_I;
      if (!LDO_LOW_I) begin
        leave_arm <= 1'h0;
      end else if (uvlo_d && !INPUT_UVLO_I) begin
        leave_arm <= 1'h1;
      end
    end
  end

  // input fault with regulator low
  // Delayed lockout bridges the cycle before the leave latch sets, so no false onset
  assign cond = {LDO_LOW_I && (INPUT_UVLO_I || uvlo_d || leave_arm), FAULT_COND_I};
  assign push_code = lowest_code(pend);
  assign grant_vec = (|pend) ? (10'h001 << (push_code - 4'h1)) : 10'h000;

  // each new fault onset waits here until its turn to be offered to the queue, which drops it when full
  always_ff @(posedge CLOCK_I) begin
    if (RESET_I) begin
      cond_d <= 10'h000;
      pend <= 10'h000;
    end else begin
      cond_d <= cond;
      pend <= (pend & ~grant_vec) | (cond & ~cond_d);
    end
  end

  assign q_pop = read_load && ptr == REG_STATUS;

  csc_fault_queue i_csc_fault_queue (
    .clk_i(CLOCK_I),
    .rst_i(RESET_I),
    .push_i(|pend),
    .code_i(push_code),
    .pop_i(q_pop),
    .head_o(q_head),
    .empty_o(q_empty)
  );

  // fault field; normal once drained and idle
  assign fault_field = q_empty ? lowest_code(cond) : q_head;

  // phase code; done hidden without termination
  assign phase_eff = (!ctrl.term_en && PHASE_I == PHASE_DONE) ? PHASE_CHARGING : PHASE_I;

  // Outputs to the charger core
  always_ff @(posedge CLOCK_I) begin
    if (RESET_I) begin
      INPUT_CAP_SEL_O <= CAP_EXT_RESISTOR;
      HOST_MODE_O <= 1'h0;
      TERM_EN_O <= CTRL_DEFAULT.term_en;
      CHARGE_INHIBIT_O <= CTRL_DEFAULT.inhibit;
      CONVERTER_STANDBY_O <= CTRL_DEFAULT.converter_standby_sel;
      WDOG_EXPIRED_O <= WDOG_FLAG_RESET;
      STAT_PIN_O <= 1'h0;
      STAT_PIN_OEN_O <= 1'h1;
    end else begin
      INPUT_CAP_SEL_O <= host_mode ? ctrl.input_current_cap_sel : CAP_EXT_RESISTOR;
      HOST_MODE_O <= host_mode;
      TERM_EN_O <= ctrl.term_en;
      CHARGE_INHIBIT_O <= ctrl.inhibit;
      CONVERTER_STANDBY_O <= ctrl.converter_standby_sel;
      WDOG_EXPIRED_O <= watchdog_expired_flag;
      STAT_PIN_O <= 1'h0;
      // indicator pulls low while charging, released when disabled
      STAT_PIN_OEN_O <= !(ctrl.ind_en && phase_eff == PHASE_CHARGING);
    end
  end

endmodule : csc_regs

/* File: testbench/csc_host_model.sv */
`timescale 1ns/10ps
module csc_host_model
  import csc_pkg::*;
(
  input wire logic sda_i,
  output logic scl_o,
  output logic sda_o
);
  localparam time QTR = 100ns;
  initial begin
    scl_o = 1'h1;
    sda_o = 1'h1;
  end
  // start framing; odd offset keeps edges off the system clock
  task automatic start_cond();
    #17ns;
    // Slave lets go of its acknowledge late; raising the clock first would fake a stop
    #QTR;
    sda_o = 1'h1;
    #QTR;
    scl_o = 1'h1;
    #QTR;
    sda_o = 1'h0;
    #QTR;
    scl_o = 1'h0;
  endtask : start_cond
  task automatic stop_cond();
    #QTR;
    sda_o = 1'h0;
    #QTR;
    scl_o = 1'h1;
    #QTR;
    sda_o = 1'h1;
    #QTR;
  endtask : stop_cond
  // Data moves only while the clock is low, sampled mid-high
  task automatic clk_bit(input logic b, output logic s);
    #QTR;
    sda_o = b;
    #QTR;
    scl_o = 1'h1;
    #QTR;
    s = sda_i;
    #QTR;
    scl_o = 1'h0;
  endtask : clk_bit
  // eight bits MSB first, ninth is acknowledge
  task automatic xfer(input logic [7:0] tx, input logic mack, output logic [7:0] rx,
                      output logic ack);
    for (int i = 7; i >= 0; i--) begin
      clk_bit(tx[i], rx[i]);
    end
    clk_bit(mack, ack);
  endtask : xfer
  task automatic write_reg(input logic [7:0] ptr, input logic [7:0] data,
                           output logic [2:0] acks);
    logic [7:0] rx;
    start_cond();
    xfer({DEV_ADDR, 1'h0}, 1'h1, rx, acks[2]);
    xfer(ptr, 1'h1, rx, acks[1]);
    xfer(data, 1'h1, rx, acks[0]);
    stop_cond();
  endtask : write_reg
  task automatic read_reg(input logic [7:0] ptr, output logic [7:0] data,
                          output logic [2:0] acks);
    logic nack;
    start_cond();
    xfer({DEV_ADDR, 1'h0}, 1'h1, data, acks[2]);
    xfer(ptr, 1'h1, data, acks[1]);
    start_cond();
    xfer({DEV_ADDR, 1'h1}, 1'h1, data, acks[0]);
    xfer(8'hFF, 1'h1, data, nack);
    stop_cond();
  endtask : read_reg
  task automatic probe(input logic [6:0] addr, output logic ack);
    logic [7:0] rx;
    start_cond();
    xfer({addr, 1'h0}, 1'h1, rx, ack);
    stop_cond();
  endtask : probe
endmodule : csc_host_model

/* File: testbench/csc_regs_asserts.sv */
`timescale 1ns/10ps
module csc_regs_chk
  import csc_pkg::*;
#(
  parameter int unsigned WDOG_CYCLES = WDOG_CYCLES_DEFAULT
) (
  input wire logic CLOCK_I,
  input wire logic RESET_I,
  input wire logic SDA_O,
  input wire logic SDA_OEN_O,
  input wire logic [1:0] PHASE_I,
  input wire logic STAT_PIN_O,
  input wire logic STAT_PIN_OEN_O,
  input wire logic [2:0] INPUT_CAP_SEL_O,
  input wire logic HOST_MODE_O,
  input wire logic TERM_EN_O,
  input wire logic CHARGE_INHIBIT_O,
  input wire logic CONVERTER_STANDBY_O,
  input wire logic WDOG_EXPIRED_O
);
  default clocking cb @(posedge CLOCK_I);
  endclocking
  default disable iff (RESET_I);
  // Cycles since the slave last pulled the data line; ties updates to bus traffic
  logic [7:0] ack_age;
  logic [1:0] ph1;
  logic [1:0] ph2;
  always_ff @(posedge CLOCK_I) begin
    if (RESET_I) begin
      ack_age <= 8'hFF;
    end else if (!SDA_OEN_O) begin
      ack_age <= 8'h00;
    end else if (ack_age != 8'hFF) begin
      ack_age <= ack_age + 8'h01;
    end
  end
  always_ff @(posedge CLOCK_I) begin
    ph1 <= PHASE_I;
    ph2 <= ph1;
  end
  reset_dflt_a: assert property (
    $fell(RESET_I) |-> SDA_OEN_O && STAT_PIN_OEN_O && INPUT_CAP_SEL_O == CAP_EXT_RESISTOR
      && !HOST_MODE_O && TERM_EN_O && !CHARGE_INHIBIT_O && !CONVERTER_STANDBY_O
      && !WDOG_EXPIRED_O) else $error("outputs not at defaults after reset");
  sda_sink_a: assert property (SDA_O == 1'h0) else $error("data pin driven high");
  stat_sink_a: assert property (STAT_PIN_O == 1'h0) else $error("indicator driven high");
  cap_standalone_a: assert property (
    !HOST_MODE_O |-> INPUT_CAP_SEL_O == CAP_EXT_RESISTOR) else $error("cap code outside host");
  expiry_dflt_a: assert property (
    $rose(WDOG_EXPIRED_O) |-> !HOST_MODE_O && TERM_EN_O && !CHARGE_INHIBIT_O
      && !CONVERTER_STANDBY_O) else $error("expiry kept host settings");
  flag_sticky_a: assert property (
    $fell(WDOG_EXPIRED_O) && !$past(RESET_I) |-> ack_age < 8'h10)
    else $error("expiry flag cleared without a read");
  host_by_write_a: assert property (
    $rose(HOST_MODE_O) |-> ack_age < 8'h64) else $error("host mode without a write");
  ctrl_by_write_a: assert property (
    $changed({TERM_EN_O, CHARGE_INHIBIT_O, CONVERTER_STANDBY_O, INPUT_CAP_SEL_O})
      && !$past(RESET_I) |-> ack_age < 8'h64 || WDOG_EXPIRED_O)
    else $error("control changed without a write");
  stat_phase_a: assert property (
    !STAT_PIN_OEN_O && PHASE_I == ph1 && ph1 == ph2 |-> PHASE_I == PHASE_CHARGING
      || (PHASE_I == PHASE_DONE && !TERM_EN_O)) else $error("indicator in wrong phase");
endmodule : csc_regs_chk

/* File: testbench/csc_regs_bench.sv */
`timescale 1ns/10ps
module csc_regs_bench
  import csc_pkg::*;
;
  localparam int unsigned WDOG = 600;
  logic clk = 1'h0;
  logic rst, scl, sda_m, sda, sda_o, sda_oen, ldo_low, uvlo, stat, stat_oen;
  logic host, term, inhibit, standby, expired, ack;
  logic [1:0] phase;
  logic [2:0] cap;
  logic [8:0] fault_cond;
  logic [3:0] fq [4] = '{4'h1, 4'h5, 4'h9, 4'h0};
  int error_cnt = 0;
  int n_compared = 0;
  int n;
  always #25 clk = ~clk;
  assign sda = sda_m & (sda_oen | sda_o);
  csc_regs #(.WDOG_CYCLES(WDOG)) i_csc_regs (
    .CLOCK_I(clk), .RESET_I(rst), .SCL_I(scl), .SDA_I(sda), .SDA_O(sda_o),
    .SDA_OEN_O(sda_oen), .PHASE_I(phase), .FAULT_COND_I(fault_cond), .LDO_LOW_I(ldo_low),
    .INPUT_UVLO_I(uvlo), .STAT_PIN_O(stat), .STAT_PIN_OEN_O(stat_oen),
    .INPUT_CAP_SEL_O(cap), .HOST_MODE_O(host), .TERM_EN_O(term),
    .CHARGE_INHIBIT_O(inhibit), .CONVERTER_STANDBY_O(standby), .WDOG_EXPIRED_O(expired)
  );
  csc_host_model i_csc_host_model (.sda_i(sda), .scl_o(scl), .sda_o(sda_m));
  task automatic close_out();
    $display("Compared %0d, mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : close_out
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    n_compared++;
    if (seen !== exp) begin
      error_cnt++;
      $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic wr(input logic [7:0] ptr, input logic [7:0] data);
    logic [2:0] acks;
    i_csc_host_model.write_reg(ptr, data, acks);
    @(negedge clk);
    check({5'h00, acks}, 8'h00);
  endtask : wr
  task automatic rd(input logic [7:0] ptr, input logic [7:0] exp);
    logic [2:0] acks;
    logic [7:0] data;
    i_csc_host_model.read_reg(ptr, data, acks);
    @(negedge clk);
    check({5'h00, acks}, 8'h00);
    check(data, exp);
  endtask : rd
  function automatic logic [7:0] outs();
    return {1'h0, cap, host, term, inhibit, standby};
  endfunction : outs
  task automatic hold(input int c);
    repeat (c) @(negedge clk);
  endtask : hold
  initial begin
    rst = 1'h1;
    phase = PHASE_CHARGING;
    fault_cond = 9'h000;
    ldo_low = 1'h0;
    uvlo = 1'h0;
    hold(12);
    rst = 1'h0;
    hold(4);
    check(outs(), 8'h64);
    rd(REG_CONTROL, 8'h0C);
    rd(REG_STATUS, 8'h10);
    rd(8'h07, READ_UNMAPPED);
    i_csc_host_model.probe(7'h6B, ack);
    check({7'h00, ack}, 8'h01);
    for (int c = 0; c < 8; c++) begin
      wr(REG_CONTROL, {1'h0, c[2:0], 4'hC});
      check(outs(), {1'h0, c[2:0], 4'hC});
    end
    for (int p = 0; p < 4; p++) begin
      phase = p[1:0];
      rd(REG_STATUS, {2'h0, p[1:0], 4'h0});
      check({7'h00, stat_oen}, {7'h00, p != 1});
    end
    wr(REG_CONTROL, 8'h0A);
    check(outs(), 8'h0A);
    phase = PHASE_DONE;
    rd(REG_STATUS, 8'h10);
    check({7'h00, stat_oen}, 8'h00);
    wr(REG_CONTROL, 8'h03);
    check(outs(), 8'h0B);
    check({7'h00, stat_oen}, 8'h01);
    wr(REG_CONTROL, 8'hFF);
    rd(REG_CONTROL, 8'h0C);
    check(outs(), 8'h0C);
    phase = PHASE_FAULT;
    fault_cond = 9'h111;
    hold(3);
    fault_cond = 9'h000;
    for (int i = 0; i < 4; i++) begin
      rd(REG_STATUS, {4'h3, fq[i]});
    end
    ldo_low = 1'h1;
    uvlo = 1'h1;
    hold(3);
    rd(REG_STATUS, {4'h3, FAULT_IN_LDO_LOW});
    uvlo = 1'h0;
    rd(REG_STATUS, {4'h3, FAULT_IN_LDO_LOW});
    ldo_low = 1'h0;
    rd(REG_STATUS, 8'h30);
    fault_cond = 9'h002;
    hold(3);
    fault_cond = 9'h000;
    wr(REG_STATUS, 8'hBF);
    rd(REG_STATUS, 8'h32);
    rd(REG_STATUS, 8'h30);
    phase = PHASE_CHARGING;
    wr(REG_CONTROL, 8'h5A);
    check(outs(), 8'h5A);
    wr(REG_STATUS, 8'h40);
    n = 0;
    while (expired !== 1'h1 && n < 1000) begin
      @(negedge clk);
      n++;
    end
    if (n == 1000) begin
      error_cnt++;
      close_out();
    end
    check({7'h00, n > WDOG - 100 && n < WDOG + 10}, 8'h01);
    hold(2);
    check(outs(), 8'h64);
    wr(REG_STATUS, 8'h00);
    rd(REG_STATUS, 8'h90);
    rd(REG_STATUS, 8'h10);
    // Restart lands before the first period ends; the check falls after it would have
    wr(REG_STATUS, 8'h40);
    hold(150);
    wr(REG_STATUS, 8'h40);
    hold(300);
    check({7'h00, expired}, 8'h00);
    wr(REG_STATUS, 8'h00);
    hold(800);
    check({7'h00, expired}, 8'h00);
    close_out();
  end
  initial begin
    repeat (100000) @(posedge clk);
    error_cnt++;
    close_out();
  end
endmodule : csc_regs_bench
bind csc_regs csc_regs_chk #(.WDOG_CYCLES(WDOG_CYCLES)) i_csc_regs_chk (
  .CLOCK_I, .RESET_I, .SDA_O, .SDA_OEN_O, .PHASE_I, .STAT_PIN_O, .STAT_PIN_OEN_O,
  .INPUT_CAP_SEL_O, .HOST_MODE_O, .TERM_EN_O, .CHARGE_INHIBIT_O, .CONVERTER_STANDBY_O,
  .WDOG_EXPIRED_O
);
